// >>> hw/dcw_pkg.sv
// How it works
// RL1 - word0 run/stop/jog and direction codes
// RL2 - word0 bits 6-7 pick accel set
// RL3 - word0 bits 8-11 pick speed source
// RL4 - bit 12 gates accel and step fields
// RL5 - word1 frequency in 0.01 Hz units
// RL6 - word2 bit 0 raises external fault
// RL7 - word2 bit1 fault reset, bit2 base block
// RL8 - reserved bits written zero, ignored
package dcw_pkg;
  localparam logic [1:0] ADDR_MOTION = 2'h0;
  localparam logic [1:0] ADDR_FREQ = 2'h1;
  localparam logic [1:0] ADDR_FAULT = 2'h2;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam int RUN_LSB = 0;
  localparam int DIR_LSB = 4;
  localparam int ACC_LSB = 6;
  localparam int STEP_LSB = 8;
  localparam int SEL_EN_BIT = 12;
  localparam int EXT_FAULT_BIT = 0;
  localparam int FAULT_RST_BIT = 1;
  localparam int BASE_BLOCK_BIT = 2;
  localparam logic [15:0] MOTION_USED = 16'h1FF3;
  localparam logic [15:0] FAULT_USED = 16'h0007;
  // host register map
  localparam logic [2:0] HOST_MOTION = 3'h0;
  localparam logic [2:0] HOST_FREQ = 3'h1;
  localparam logic [2:0] HOST_FAULT = 3'h2;
  localparam logic [2:0] HOST_STATUS = 3'h3;
  localparam logic [2:0] HOST_DRIVE = 3'h4;
  typedef enum logic [1:0] {DCW_RUN_NONE = 2'h0, DCW_RUN_STOP = 2'h1, DCW_RUN_RUN = 2'h2, DCW_RUN_JOG = 2'h3} dcw_run_e;
  typedef enum logic [1:0] {DCW_DIR_NONE = 2'h0, DCW_DIR_FWD = 2'h1, DCW_DIR_REV = 2'h2, DCW_DIR_NONE2 = 2'h3} dcw_dir_e;
endpackage

// >>> hw/dcw_if.sv
`timescale 1ns/100ps
interface dcw_if;
  logic wr;
  logic [1:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport device (input wr, input addr, input wdata, output rdata);
  modport ctrl (output wr, output addr, output wdata, input rdata);
endinterface

// >>> hw/dcw_device.sv
`timescale 1ns/100ps
module dcw_device (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // command word link
  dcw_if.device LINK,
  // decoded drive controls
  output logic STOP_CMD,
  output logic RUN_CMD,
  output logic JOG_CMD,
  output logic FWD_CMD,
  output logic REV_CMD,
  output logic [1:0] ACCEL_SET,
  output logic [3:0] STEP_SEL,
  output logic [15:0] FREQ_CMD,
  output logic EXT_FAULT,
  output logic FAULT_RESET,
  output logic BASE_BLOCK
);
  logic [15:0] motion;
  logic [15:0] freq;
  logic [15:0] fault;
  logic [15:0] rd;
  logic [1:0] run;
  logic [1:0] dir;

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      motion <= dcw_pkg::RESET_WORD;
      freq <= dcw_pkg::RESET_WORD;
      fault <= dcw_pkg::RESET_WORD;
    end else if (LINK.wr) begin
      case (LINK.addr)
        dcw_pkg::ADDR_MOTION: begin
          motion <= LINK.wdata & dcw_pkg::MOTION_USED; // RL8
        end
        dcw_pkg::ADDR_FREQ: begin
          freq <= LINK.wdata;
        end
        dcw_pkg::ADDR_FAULT: begin
          fault <= LINK.wdata & dcw_pkg::FAULT_USED; // RL8
        end
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    case (LINK.addr)
      dcw_pkg::ADDR_MOTION: rd = motion;
      dcw_pkg::ADDR_FREQ: rd = freq;
      dcw_pkg::ADDR_FAULT: rd = fault;
      default: rd = 16'h0000;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      LINK.rdata <= 16'h0000;
    end else begin
      LINK.rdata <= rd;
    end
  end

  assign run = motion[dcw_pkg::RUN_LSB +: 2];
  assign dir = motion[dcw_pkg::DIR_LSB +: 2];

  // outputs follow the stored words one cycle later
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      STOP_CMD <= 1'b0;
      RUN_CMD <= 1'b0;
      JOG_CMD <= 1'b0;
      FWD_CMD <= 1'b0;
      REV_CMD <= 1'b0;
    end else begin
      STOP_CMD <= run == dcw_pkg::DCW_RUN_STOP; // RL1
      RUN_CMD <= run == dcw_pkg::DCW_RUN_RUN; // RL1
      JOG_CMD <= run == dcw_pkg::DCW_RUN_JOG; // RL1
      FWD_CMD <= dir == dcw_pkg::DCW_DIR_FWD; // RL1
      REV_CMD <= dir == dcw_pkg::DCW_DIR_REV; // RL1
    end
  end

  // selections held at their last enabled value while bit 12 is clear
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      ACCEL_SET <= 2'h0;
      STEP_SEL <= 4'h0;
    end else if (motion[dcw_pkg::SEL_EN_BIT]) begin // RL4
      ACCEL_SET <= motion[dcw_pkg::ACC_LSB +: 2]; // RL2
      STEP_SEL <= motion[dcw_pkg::STEP_LSB +: 4]; // RL3
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      FREQ_CMD <= 16'h0000;
    end else begin
      FREQ_CMD <= freq; // RL5
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      EXT_FAULT <= 1'b0;
      FAULT_RESET <= 1'b0;
      BASE_BLOCK <= 1'b0;
    end else begin
      EXT_FAULT <= fault[dcw_pkg::EXT_FAULT_BIT]; // RL6
      FAULT_RESET <= fault[dcw_pkg::FAULT_RST_BIT]; // RL7
      BASE_BLOCK <= fault[dcw_pkg::BASE_BLOCK_BIT]; // RL7
    end
  end
endmodule

// >>> hw/dcw_ctrl.sv
`timescale 1ns/100ps
module dcw_ctrl (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // software port
  input wire logic [2:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  // link to device
  dcw_if.ctrl LINK
);
  logic [15:0] shadow_motion;
  logic [15:0] shadow_freq;
  logic [15:0] shadow_fault;

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      LINK.wr <= 1'b0;
      LINK.addr <= 2'h0;
      LINK.wdata <= 16'h0000;
    end else begin
      LINK.wr <= WR && ADDR <= dcw_pkg::HOST_FAULT;
      if (WR || RD) begin
        LINK.addr <= ADDR[1:0];
      end
      if (WR) begin
        case (ADDR)
          dcw_pkg::HOST_MOTION: LINK.wdata <= WDATA & dcw_pkg::MOTION_USED; // RL8
          dcw_pkg::HOST_FAULT: LINK.wdata <= WDATA & dcw_pkg::FAULT_USED; // RL8
          default: LINK.wdata <= WDATA;
        endcase
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      shadow_motion <= dcw_pkg::RESET_WORD;
      shadow_freq <= dcw_pkg::RESET_WORD;
      shadow_fault <= dcw_pkg::RESET_WORD;
    end else if (WR) begin
      case (ADDR)
        dcw_pkg::HOST_MOTION: shadow_motion <= WDATA & dcw_pkg::MOTION_USED;
        dcw_pkg::HOST_FREQ: shadow_freq <= WDATA;
        dcw_pkg::HOST_FAULT: shadow_fault <= WDATA & dcw_pkg::FAULT_USED;
        default: begin
        end
      endcase
    end
  end

  // device readback lags the link by one cycle, so it shows on HOST_DRIVE reads only as a snapshot
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      RDATA <= 16'h0000;
    end else begin
      if (RD) begin
        case (ADDR)
          dcw_pkg::HOST_MOTION: RDATA <= shadow_motion;
          dcw_pkg::HOST_FREQ: RDATA <= shadow_freq;
          dcw_pkg::HOST_FAULT: RDATA <= shadow_fault;
          dcw_pkg::HOST_STATUS: RDATA <= {15'h0000, LINK.wr};
          dcw_pkg::HOST_DRIVE: RDATA <= LINK.rdata;
          default: RDATA <= 16'h0000;
        endcase
      end
    end
  end
endmodule

// >>> testbench/dcw_assertions.sv
`timescale 1ns/100ps
module dcw_assertions (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // link
  input wire logic wr,
  input wire logic [1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  property p_motion;
    wr && addr == 2'h0 ##1 !wr && addr == 2'h0 |=> rdata == ($past(wdata, 2) & dcw_pkg::MOTION_USED);
  endproperty
  a_motion: assert property (p_motion) else $error("motion word readback wrong");
  property p_freq;
    wr && addr == 2'h1 ##1 !wr && addr == 2'h1 |=> rdata == $past(wdata, 2);
  endproperty
  a_freq: assert property (p_freq) else $error("frequency word readback wrong");
  property p_fault;
    wr && addr == 2'h2 ##1 !wr && addr == 2'h2 |=> rdata == ($past(wdata, 2) & dcw_pkg::FAULT_USED);
  endproperty
  a_fault: assert property (p_fault) else $error("fault word readback wrong");
  property p_fault_rsvd;
    $past(addr) == 2'h2 |-> rdata[15:3] == 13'h0000;
  endproperty
  a_fault_rsvd: assert property (p_fault_rsvd) else $error("fault word spare bits set");
  property p_motion_rsvd;
    $past(addr) == 2'h0 |-> (rdata & ~dcw_pkg::MOTION_USED) == 16'h0000;
  endproperty
  a_motion_rsvd: assert property (p_motion_rsvd) else $error("motion word spare bits set");
  // a quiet link must not disturb the read path
  property p_hold;
    !wr ##1 $stable(addr) |=> $stable(rdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved without a write");
endmodule

// >>> testbench/drive_command_word_decoder_tb.sv
`timescale 1ns/100ps
module drive_command_word_decoder_tb;
  logic SYS_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic [2:0] ADDR = 3'h0;
  logic [15:0] WDATA = 16'h0000;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [15:0] RDATA, FREQ_CMD;
  logic STOP_CMD, RUN_CMD, JOG_CMD, FWD_CMD, REV_CMD, EXT_FAULT, FAULT_RESET, BASE_BLOCK;
  logic [1:0] ACCEL_SET;
  logic [3:0] STEP_SEL;
  int n_fail = 0;
  int n_tests = 0;
  int cycles = 0;
  dcw_if link ();
  dcw_ctrl u_dcw_ctrl (.SYS_CLK, .RST_N, .ADDR, .WDATA, .WR, .RD, .RDATA, .LINK(link));
  dcw_device u_dcw_device (.SYS_CLK, .RST_N, .LINK(link), .STOP_CMD, .RUN_CMD, .JOG_CMD, .FWD_CMD, .REV_CMD,
    .ACCEL_SET, .STEP_SEL, .FREQ_CMD, .EXT_FAULT, .FAULT_RESET, .BASE_BLOCK);
  dcw_assertions u_dcw_assertions (.SYS_CLK, .RST_N, .wr(link.wr), .addr(link.addr), .wdata(link.wdata),
    .rdata(link.rdata));
  always #12.5 SYS_CLK = ~SYS_CLK;
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge SYS_CLK) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // three edges cover the ctrl to device to output path
  task automatic put(input logic [2:0] a, input logic [15:0] d);
    @(posedge SYS_CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge SYS_CLK);
    WR <= 1'b0;
    repeat (3) @(posedge SYS_CLK);
    #1;
  endtask
  task automatic get(input logic [2:0] a, input logic [15:0] exp);
    @(posedge SYS_CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge SYS_CLK);
    RD <= 1'b0;
    #1;
    check("RDATA", RDATA, exp);
  endtask
  // spare bits are set on purpose to show they are dropped
  task automatic run_dir();
    for (int i = 0; i < 4; i++) begin
      put(3'h0, 16'hE00C | 16'(i << 4) | 16'(i));
      check("run", {13'h0, JOG_CMD, RUN_CMD, STOP_CMD}, i == 0 ? 16'h0 : 16'(1 << (i - 1)));
      check("dir", {14'h0, REV_CMD, FWD_CMD}, i == 0 || i == 3 ? 16'h0 : 16'(1 << (i - 1)));
      get(3'h0, 16'(i << 4) | 16'(i));
    end
  endtask
  task automatic select();
    put(3'h0, 16'h1F80);
    check("sel", {10'h0, ACCEL_SET, STEP_SEL}, 16'h002F);
    put(3'h0, 16'h0340);
    check("hold", {10'h0, ACCEL_SET, STEP_SEL}, 16'h002F);
    put(3'h0, 16'h1000);
    check("master", {10'h0, ACCEL_SET, STEP_SEL}, 16'h0000);
  endtask
  task automatic freq();
    put(3'h1, 16'h1770);
    check("freq", FREQ_CMD, 16'h1770);
    get(3'h1, 16'h1770);
    put(3'h1, 16'hFFFF);
    check("freq", FREQ_CMD, 16'hFFFF);
  endtask
  task automatic fault();
    for (int b = 0; b < 3; b++) begin
      put(3'h2, 16'hFFF8 | 16'(1 << b));
      check("fault", {13'h0, BASE_BLOCK, FAULT_RESET, EXT_FAULT}, 16'(1 << b));
      get(3'h2, 16'(1 << b));
    end
    put(3'h2, 16'h0000);
    check("fault", {13'h0, BASE_BLOCK, FAULT_RESET, EXT_FAULT}, 16'h0000);
  endtask
  task automatic unmapped();
    put(3'h5, 16'hABCD);
    get(3'h5, 16'h0000);
    check("freq", FREQ_CMD, 16'hFFFF);
  endtask
  // a read straight after a write catches the link strobe still pending
  task automatic status_drive();
    @(posedge SYS_CLK);
    ADDR <= 3'h1;
    WDATA <= 16'h0BB8;
    WR <= 1'b1;
    @(posedge SYS_CLK);
    ADDR <= 3'h3;
    WR <= 1'b0;
    RD <= 1'b1;
    @(posedge SYS_CLK);
    RD <= 1'b0;
    #1;
    check("status", RDATA, 16'h0001);
    get(3'h3, 16'h0000);
    get(3'h1, 16'h0BB8);
    get(3'h4, 16'h0BB8);
    check("freq", FREQ_CMD, 16'h0BB8);
  endtask
  // reset held for one edge in mid run must clear the frequency words and FREQ_CMD
  task automatic mid_reset();
    @(posedge SYS_CLK);
    RST_N <= 1'b0;
    @(posedge SYS_CLK);
    RST_N <= 1'b1;
    #1;
    check("reset freq", FREQ_CMD, 16'h0000);
    get(3'h1, 16'h0000);
    get(3'h4, 16'h0000);
  endtask
  initial begin
    repeat (2) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    run_dir();
    select();
    freq();
    fault();
    unmapped();
    status_drive();
    mid_reset();
    give_verdict();
  end
endmodule
